// file: src/mmd_decoder.sv
// Memory space decoder: code, internal RAM, stack and on-chip onchip_external_ram
//
// Operation
// - Flash occupies code space from zero to 0x1FFF, 0x0FFF or 0x07FF.
// - Last flash byte is the lock byte; higher code addresses reserved.
// - Code-move reads flash; external-move writes go to onchip_external_ram or flash.
// - 512 bytes of RAM: 256 internal, 256 in external space.
// - Lower 128 internal bytes reachable directly and indirectly.
// - Above 0x7F, direct reaches SFRs, indirect reaches upper RAM.
// - Bytes 0x00-0x1F are four banks of eight registers, status-selected.
// - Indirect modes use registers zero and one as index.
// - Bytes 0x20-0x2F also form bits 0x00-0x7F, eight per byte.
// - Bit or byte access chosen by operand type, not address.
// - Push writes at pointer plus one, then increments the pointer.
// - Reset sets the stack pointer to 0x07.
// - Stack may use all 256 internal bytes, including upper RAM.
// - On-chip onchip_external_ram decodes only the low address byte.
// - Data pointer is two separately accessible byte registers.
// - External-move to on-chip onchip_external_ram needs no initialization.
`timescale 1ns/10ps
module mmd_decoder
  import mmd_pkg::*;
#(
  parameter mmd_flash_sz_t FLASH_SIZE = FLASH_8K
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire mmd_req_t req,
  input wire logic bank_select_low_bit,
  input wire logic bank_select_high_bit,
  input wire logic xmove_flash_wr_en,
  input wire logic xmove_flash_erase,
  output mmd_rsp_t rsp,
  output mmd_flash_t flash_req,
  output mmd_sfr_t sfr_req,
  output logic [7:0] stack_ptr,
  output logic [15:0] data_pointer_16
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [7:0] sp_q, sp_d;
  logic [7:0] ptr_lo_q, ptr_lo_d;
  logic [7:0] ptr_hi_q, ptr_hi_d;
  mmd_rsp_t rsp_q, rsp_d;
  mmd_flash_t flash_q, flash_d;
  mmd_sfr_t sfr_q, sfr_d;

  logic [1:0] bank;
  logic [2:0] idx_sel;
  logic [7:0] iram_ra;
  logic [7:0] iram_rb;
  logic [7:0] iram_da;
  logic [7:0] iram_db;
  logic iram_we;
  logic [7:0] iram_waddr;
  logic [7:0] iram_wdata;
  logic [7:0] onchip_external_ram_addr;
  logic [7:0] onchip_external_ram_rdata;
  logic onchip_external_ram_we;
  logic [7:0] bit_byte;
  logic code_in_flash;
  logic code_lock;
  logic code_rsvd;
  logic x_to_flash;

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  mmd_ram u_iram (
    .clk(clk),
    .we(iram_we),
    .waddr(iram_waddr),
    .wdata(iram_wdata),
    .raddr_a(iram_ra),
    .rdata_a(iram_da),
    .raddr_b(iram_rb),
    .rdata_b(iram_db)
  );

  mmd_ram u_onchip_external_ram (
    .clk(clk),
    .we(onchip_external_ram_we),
    .waddr(onchip_external_ram_addr),
    .wdata(req.wdata),
    .raddr_a(onchip_external_ram_addr),
    .rdata_a(onchip_external_ram_rdata),
    .raddr_b(onchip_external_ram_addr),
    .rdata_b()
  );

  mmd_flash_map #(
    .SIZE(FLASH_SIZE)
  ) u_map (
    .addr(req.addr),
    .in_flash(code_in_flash),
    .lock_byte(code_lock),
    .reserved(code_rsvd)
  );

  // ------------------------------------------------------------
  // Read address decode
  // ------------------------------------------------------------
  assign bank = {bank_select_high_bit, bank_select_low_bit};
  // Index forms only see registers zero and one, whatever else is set
  assign idx_sel = (req.op == OP_REG) ? req.reg_sel
                 : {2'b00, req.reg_sel[0]};
  assign iram_ra = {3'b000, bank, idx_sel};

  always_comb begin
    case (req.op)
      OP_IND: iram_rb = iram_da;
      OP_BIT: iram_rb = BIT_BASE + {4'h0, req.addr[6:3]};
      OP_POP: iram_rb = sp_q;
      default: iram_rb = req.addr[7:0];
    endcase
  end

  // High address byte never reaches the 256-byte onchip_external_ram
  assign onchip_external_ram_addr = (req.op == OP_XMOVE_PTR) ? ptr_lo_q : iram_da;
  assign x_to_flash = req.wr && xmove_flash_wr_en;

  // ------------------------------------------------------------
  // Next-state decode
  // ------------------------------------------------------------
  always_comb begin
    sp_d = sp_q;
    ptr_lo_d = ptr_lo_q;
    ptr_hi_d = ptr_hi_q;
    rsp_d = '0;
    flash_d = '0;
    sfr_d = '0;
    iram_we = 1'b0;
    iram_waddr = iram_rb;
    iram_wdata = req.wdata;
    onchip_external_ram_we = 1'b0;
    bit_byte = iram_db;
    bit_byte[req.addr[2:0]] = req.wdata[0];
    rsp_d.valid = req.valid;
    if (req.valid) begin
      case (req.op)
        OP_CODE: begin
          // Code space is read-only here; flash writes use the xmove path
          rsp_d.err = code_rsvd;
          flash_d.rd = code_in_flash;
          flash_d.lock_byte = code_lock;
          flash_d.addr = req.addr;
        end
        OP_REG: begin
          iram_waddr = iram_ra;
          iram_we = req.wr;
          rsp_d.rdata = iram_da;
        end
        OP_DIR: begin
          if (req.addr[7:0] <= LOWER_TOP) begin
            iram_we = req.wr;
            rsp_d.rdata = iram_db;
          end else if (req.addr[7:0] == SFR_SP) begin
            rsp_d.rdata = sp_q;
            if (req.wr) begin
              sp_d = req.wdata;
            end
          end else if (req.addr[7:0] == SFR_PTR_LO) begin
            rsp_d.rdata = ptr_lo_q;
            if (req.wr) begin
              ptr_lo_d = req.wdata;
            end
          end else if (req.addr[7:0] == SFR_PTR_HI) begin
            rsp_d.rdata = ptr_hi_q;
            if (req.wr) begin
              ptr_hi_d = req.wdata;
            end
          end else begin
            rsp_d.from_sfr = 1'b1;
            sfr_d.valid = 1'b1;
            sfr_d.wr = req.wr;
            sfr_d.addr = req.addr[7:0];
            sfr_d.wdata = req.wdata;
          end
        end
        OP_IND: begin
          iram_we = req.wr;
          rsp_d.rdata = iram_db;
        end
        OP_BIT: begin
          if (req.addr[7]) begin
            // Bit numbers above 0x7F belong to bit-capable SFRs
            rsp_d.from_sfr = 1'b1;
            sfr_d.valid = 1'b1;
            sfr_d.wr = req.wr;
            sfr_d.is_bit = 1'b1;
            sfr_d.addr = req.addr[7:0];
            sfr_d.wdata = req.wdata;
          end else begin
            rsp_d.rdata = {7'h00, iram_db[req.addr[2:0]]};
            iram_wdata = bit_byte;
            iram_we = req.wr;
          end
        end
        OP_PUSH: begin
          // Pointer wraps through all 256 bytes, upper half included
          iram_waddr = sp_q + 8'h01;
          iram_we = 1'b1;
          sp_d = sp_q + 8'h01;
        end
        OP_POP: begin
          rsp_d.rdata = iram_db;
          sp_d = sp_q - 8'h01;
        end
        OP_XMOVE_PTR, OP_XRI: begin
          if (x_to_flash) begin
            // Ri form has no high byte, so its flash target is page zero
            flash_d.wr = ~xmove_flash_erase;
            flash_d.erase = xmove_flash_erase;
            flash_d.addr = (req.op == OP_XMOVE_PTR) ? {ptr_hi_q, ptr_lo_q}
                         : {8'h00, iram_da};
            flash_d.wdata = req.wdata;
          end else begin
            onchip_external_ram_we = req.wr;
            rsp_d.rdata = onchip_external_ram_rdata;
          end
        end
        OP_PTR_LD: begin
          ptr_hi_d = req.addr[15:8];
          ptr_lo_d = req.addr[7:0];
        end
        default: begin
          rsp_d.valid = 1'b1;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sp_q <= SP_RESET;
      ptr_lo_q <= PTR_RESET;
      ptr_hi_q <= PTR_RESET;
      rsp_q <= '0;
      flash_q <= '0;
      sfr_q <= '0;
    end else begin
      sp_q <= sp_d;
      ptr_lo_q <= ptr_lo_d;
      ptr_hi_q <= ptr_hi_d;
      rsp_q <= rsp_d;
      flash_q <= flash_d;
      sfr_q <= sfr_d;
    end
  end

  assign rsp = rsp_q;
  assign flash_req = flash_q;
  assign sfr_req = sfr_q;
  assign stack_ptr = sp_q;
  assign data_pointer_16 = {ptr_hi_q, ptr_lo_q};

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sp_reset_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      $fell(sys_rst) |-> stack_ptr == SP_RESET)
    else $error("Stack pointer not 0x07 after reset");

  push_order_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      (req.valid && req.op == OP_PUSH)
      |-> iram_we && iram_waddr == stack_ptr + 8'h01
      ##1 stack_ptr == $past(stack_ptr) + 8'h01)
    else $error("Push wrote wrong place or pointer not bumped");

  pop_order_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      (req.valid && req.op == OP_POP)
      |-> iram_rb == stack_ptr
      ##1 stack_ptr == $past(stack_ptr) - 8'h01)
    else $error("Pop read wrong place or pointer not dropped");

  bank_map_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      (req.valid && req.op == OP_REG)
      |-> iram_ra == {3'b000, bank_select_high_bit,
                      bank_select_low_bit, req.reg_sel})
    else $error("Register mapped outside selected bank");

  dir_high_sfr_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      (req.valid && req.op == OP_DIR && req.addr[7]
       && req.addr[7:0] != SFR_SP && req.addr[7:0] != SFR_PTR_LO
       && req.addr[7:0] != SFR_PTR_HI && !iram_we)
      |=> sfr_req.valid && rsp.from_sfr)
    else $error("High direct access did not reach SPECIAL_FUNCTION_REGISTER space");

  ind_high_ram_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      (req.valid && req.op == OP_IND)
      |-> iram_rb == iram_da ##1 !sfr_req.valid)
    else $error("Indirect access leaked into SPECIAL_FUNCTION_REGISTER space");

  bit_byte_map_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      (req.valid && req.op == OP_BIT && !req.addr[7])
      |-> iram_rb == 8'h20 + {4'h0, req.addr[6:3]})
    else $error("Bit address mapped to wrong byte");

  onchip_external_ram_low_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      (req.valid && req.op == OP_XMOVE_PTR)
      |-> onchip_external_ram_addr == data_pointer_16[7:0])
    else $error("Onchip_external_ram address not taken from pointer low byte");

  code_rsvd_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      (req.valid && req.op == OP_CODE && code_rsvd)
      |=> rsp.err && !flash_req.rd)
    else $error("Reserved code address not refused");

  xmove_flash_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      (req.valid && req.op == OP_XRI && req.wr && xmove_flash_wr_en)
      |-> !onchip_external_ram_we ##1 (flash_req.wr || flash_req.erase))
    else $error("Flash-directed xmove write went to onchip_external_ram");

  bit_sfr_fwd_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      (req.valid && req.op == OP_BIT && req.addr[7])
      |=> sfr_req.valid && sfr_req.is_bit && rsp.from_sfr)
    else $error("High bit number not forwarded as a bit access");

  index_reg_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      (req.valid && (req.op == OP_IND || req.op == OP_XRI))
      |-> iram_ra == {3'b000, bank_select_high_bit, bank_select_low_bit,
                      2'b00, req.reg_sel[0]})
    else $error("Index taken outside registers zero and one");

  dir_low_ram_a:
    assert property (@(posedge clk) disable iff (sys_rst)
      (req.valid && req.op == OP_DIR && !req.addr[7])
      |-> iram_rb == req.addr[7:0] ##1 (!sfr_req.valid && !rsp.from_sfr))
    else $error("Low direct access left internal RAM");

endmodule // mmd_decoder

// file: src/mmd_flash_map.sv
// Code space map: flash region, lock byte and reserved range
`timescale 1ns/10ps
module mmd_flash_map
  import mmd_pkg::*;
#(
  parameter mmd_flash_sz_t SIZE = FLASH_8K
)
(
  input wire logic [15:0] addr,
  output logic in_flash,
  output logic lock_byte,
  output logic reserved
);

  logic [15:0] last;

  always_comb begin
    case (SIZE)
      FLASH_4K: last = FLASH_LAST_4K;
      FLASH_2K: last = FLASH_LAST_2K;
      default: last = FLASH_LAST_8K;
    endcase
  end

  assign in_flash = (addr <= last);
  assign lock_byte = (addr == last);
  assign reserved = (addr > last);

endmodule // mmd_flash_map

// file: src/mmd_pkg.sv
// Package: memory space decoder constants, operations and carriers
package mmd_pkg;

  // ------------------------------------------------------------
  // Sizes and addresses
  // ------------------------------------------------------------
  localparam int unsigned IRAM_DEPTH = 256;
  localparam int unsigned ONCHIP_EXTERNAL_RAM_DEPTH = 256;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] LOWER_TOP = 8'h7F;
  localparam logic [7:0] BIT_BASE = 8'h20;
  localparam logic [7:0] SFR_SP = 8'h81;
  localparam logic [7:0] SFR_PTR_LO = 8'h82;
  localparam logic [7:0] SFR_PTR_HI = 8'h83;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [15:0] FLASH_LAST_8K = 16'h1FFF;
  localparam logic [15:0] FLASH_LAST_4K = 16'h0FFF;
  localparam logic [15:0] FLASH_LAST_2K = 16'h07FF;

  // ------------------------------------------------------------
  // Enumerations
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    FLASH_8K = 2'h0,
    FLASH_4K = 2'h1,
    FLASH_2K = 2'h2
  } mmd_flash_sz_t;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_CODE = 4'h1,
    OP_DIR = 4'h2,
    OP_IND = 4'h3,
    OP_REG = 4'h4,
    OP_BIT = 4'h5,
    OP_PUSH = 4'h6,
    OP_POP = 4'h7,
    OP_XMOVE_PTR = 4'h8,
    OP_XRI = 4'h9,
    OP_PTR_LD = 4'hA
  } mmd_op_t;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic valid;
    mmd_op_t op;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [2:0] reg_sel;
  } mmd_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
    logic from_sfr;
    logic err;
  } mmd_rsp_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic erase;
    logic lock_byte;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mmd_flash_t;

  typedef struct packed {
    logic valid;
    logic wr;
    logic is_bit;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mmd_sfr_t;

endpackage

// file: src/mmd_ram.sv
// Byte-wide flip-flop RAM, one write port and two read ports
`timescale 1ns/10ps
module mmd_ram
  import mmd_pkg::*;
(
  input wire logic clk,
  input wire logic we,
  input wire logic [7:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] raddr_a,
  output logic [7:0] rdata_a,
  input wire logic [7:0] raddr_b,
  output logic [7:0] rdata_b
);

  logic [7:0] mem_q [IRAM_DEPTH];
  logic [7:0] mem_d [IRAM_DEPTH];

  // Contents carry no reset: usable at once, values left to software
  for (genvar i = 0; i < IRAM_DEPTH; i++) begin : g_entry
    always_comb begin
      mem_d[i] = mem_q[i];
      if (we && waddr == 8'(i)) begin
        mem_d[i] = wdata;
      end
    end

    always_ff @(posedge clk) begin
      mem_q[i] <= mem_d[i];
    end
  end

  assign rdata_a = mem_q[raddr_a];
  assign rdata_b = mem_q[raddr_b];

endmodule // mmd_ram

// file: tb/mmd_core_model.sv
// Core-side model: issues one request at a time and captures the answer
`timescale 1ns/10ps
module mmd_core_model
  import mmd_pkg::*;
(
  input wire logic clk,
  input wire mmd_rsp_t rsp,
  output mmd_req_t req
);
  initial req = '0;

  // Idle fields are scrambled so a decoder that ignores valid shows up
  task automatic issue(input mmd_op_t op, input logic wr,
      input logic [15:0] addr, input logic [7:0] wdata,
      input logic [2:0] reg_sel, output mmd_rsp_t got);
    mmd_req_t r;
    r = '{valid: 1'b1, op: op, wr: wr, addr: addr, wdata: wdata,
          reg_sel: reg_sel};
    @(posedge clk);
    req <= r;
    @(posedge clk);
    r = ~r;
    r.valid = 1'b0;
    req <= r;
    #1;
    got = rsp;
  endtask
endmodule // mmd_core_model

// file: tb/testbench.sv
// Self-checking bench for the memory space decoder
`timescale 1ns/10ps
module testbench;
  import mmd_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic bank_lo = 1'b0;
  logic bank_hi = 1'b0;
  logic flash_wr = 1'b0;
  logic erase = 1'b0;
  mmd_req_t req;
  mmd_rsp_t rsp;
  mmd_rsp_t got;
  mmd_flash_t flash_req;
  mmd_sfr_t sfr_req;
  logic [7:0] stack_ptr;
  logic [15:0] data_ptr;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;

  mmd_decoder #(.FLASH_SIZE(FLASH_4K)) mmd_decoder_inst (
    .clk(clk), .sys_rst(sys_rst), .req(req),
    .bank_select_low_bit(bank_lo), .bank_select_high_bit(bank_hi),
    .xmove_flash_wr_en(flash_wr), .xmove_flash_erase(erase),
    .rsp(rsp), .flash_req(flash_req), .sfr_req(sfr_req),
    .stack_ptr(stack_ptr), .data_pointer_16(data_ptr));

  mmd_core_model mmd_core_model_inst (.clk(clk), .rsp(rsp), .req(req));

  initial begin
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  task automatic complete_run();
    if (fail_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic op(input mmd_op_t o, input logic w, input logic [15:0] a,
      input logic [7:0] d, input logic [2:0] s);
    mmd_core_model_inst.issue(o, w, a, d, s, got);
    check("rsp valid", 16'(got.valid), 16'h0001);
  endtask

  task automatic set_ctl(input logic b1, input logic b0, input logic fw,
      input logic fe);
    @(posedge clk);
    bank_hi <= b1;
    bank_lo <= b0;
    flash_wr <= fw;
    erase <= fe;
  endtask

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_stack();
    check("sp reset", 16'(stack_ptr), 16'(SP_RESET));
    op(OP_PUSH, 1'b1, 16'h0000, 8'hA5, 3'h0);
    check("sp push", 16'(stack_ptr), 16'h0008);
    op(OP_DIR, 1'b0, 16'h0008, 8'h00, 3'h0);
    check("push data", 16'(got.rdata), 16'h00A5);
    op(OP_DIR, 1'b1, 16'h0081, 8'hFE, 3'h0);
    op(OP_PUSH, 1'b1, 16'h0000, 8'h11, 3'h0);
    op(OP_PUSH, 1'b1, 16'h0000, 8'h22, 3'h0);
    check("sp wrap", 16'(stack_ptr), 16'h0000);
    op(OP_POP, 1'b0, 16'h0000, 8'h00, 3'h0);
    check("pop data", 16'(got.rdata), 16'h0022);
    op(OP_POP, 1'b0, 16'h0000, 8'h00, 3'h0);
    check("pop data 2", 16'(got.rdata), 16'h0011);
    check("sp pop", 16'(stack_ptr), 16'h00FE);
  endtask

  task automatic code_chk(input logic [15:0] a, input logic rd,
      input logic lk, input logic er);
    op(OP_CODE, 1'b0, a, 8'h00, 3'h0);
    check("flash rd", 16'(flash_req.rd), 16'(rd));
    check("lock byte", 16'(flash_req.lock_byte), 16'(lk));
    check("code err", 16'(got.err), 16'(er));
  endtask

  task automatic t_code();
    code_chk(16'h0000, 1'b1, 1'b0, 1'b0);
    code_chk(FLASH_LAST_4K, 1'b1, 1'b1, 1'b0);
    check("flash addr", flash_req.addr, FLASH_LAST_4K);
    code_chk(16'h1000, 1'b0, 1'b0, 1'b1);
  endtask

  task automatic t_xmove();
    op(OP_PTR_LD, 1'b1, 16'h1234, 8'h00, 3'h0);
    check("ptr load", data_ptr, 16'h1234);
    set_ctl(1'b0, 1'b0, 1'b1, 1'b0);
    op(OP_XMOVE_PTR, 1'b1, 16'h0000, 8'hA5, 3'h0);
    check("flash wr", {flash_req.wr, flash_req.erase}, 16'h0002);
    check("flash waddr", flash_req.addr, 16'h1234);
    set_ctl(1'b0, 1'b0, 1'b1, 1'b1);
    op(OP_XMOVE_PTR, 1'b1, 16'h0000, 8'hA5, 3'h0);
    check("flash erase", 16'(flash_req.erase), 16'h0001);
    set_ctl(1'b0, 1'b0, 1'b0, 1'b0);
    op(OP_PTR_LD, 1'b1, 16'hAB34, 8'h00, 3'h0);
    op(OP_XMOVE_PTR, 1'b1, 16'h0000, 8'h3C, 3'h0);
    check("onchip_external_ram no flash", 16'(flash_req.wr), 16'h0000);
    op(OP_REG, 1'b1, 16'h0000, 8'h34, 3'h0);
    op(OP_XRI, 1'b0, 16'h0000, 8'h00, 3'h0);
    check("onchip_external_ram via index", 16'(got.rdata), 16'h003C);
    set_ctl(1'b0, 1'b0, 1'b1, 1'b0);
    op(OP_XRI, 1'b1, 16'h0000, 8'h77, 3'h0);
    check("index flash addr", flash_req.addr, 16'h0034);
    check("index flash data", 16'(flash_req.wdata), 16'h0077);
    set_ctl(1'b0, 1'b0, 1'b0, 1'b0);
    op(OP_DIR, 1'b1, 16'h0083, 8'h00, 3'h0);
    check("ptr high", data_ptr, 16'h0034);
    op(OP_DIR, 1'b0, 16'h0082, 8'h00, 3'h0);
    check("ptr low read", {got.from_sfr, got.rdata}, 16'h0034);
    op(OP_XMOVE_PTR, 1'b0, 16'h0000, 8'h00, 3'h0);
    check("onchip_external_ram low byte", 16'(got.rdata), 16'h003C);
  endtask

  task automatic t_banks();
    for (int b = 0; b < 4; b++) begin
      set_ctl(b[1], b[0], 1'b0, 1'b0);
      op(OP_REG, 1'b1, 16'h0000, 8'(8'h50 + b), 3'h5);
    end
    for (int b = 0; b < 4; b++) begin
      op(OP_DIR, 1'b0, 16'(b * 8 + 5), 8'h00, 3'h0);
      check("bank reg", 16'(got.rdata), 16'(8'h50 + b));
    end
  endtask

  task automatic t_upper();
    set_ctl(1'b1, 1'b0, 1'b0, 1'b0);
    op(OP_REG, 1'b1, 16'h0000, 8'h90, 3'h1);
    op(OP_IND, 1'b1, 16'h0000, 8'hC3, 3'h1);
    check("ind no sfr", 16'(sfr_req.valid), 16'h0000);
    op(OP_DIR, 1'b0, 16'h0090, 8'h00, 3'h0);
    check("dir sfr", {sfr_req.valid, got.from_sfr}, 16'h0003);
    check("sfr addr", 16'(sfr_req.addr), 16'h0090);
    op(OP_IND, 1'b0, 16'h0000, 8'h00, 3'h1);
    check("upper ram", 16'(got.rdata), 16'h00C3);
    op(OP_DIR, 1'b1, 16'h0040, 8'h11, 3'h0);
    op(OP_REG, 1'b1, 16'h0000, 8'h40, 3'h0);
    op(OP_IND, 1'b0, 16'h0000, 8'h00, 3'h0);
    check("lower ind", 16'(got.rdata), 16'h0011);
  endtask

  task automatic t_bits();
    op(OP_DIR, 1'b1, 16'h0022, 8'h08, 3'h0);
    op(OP_DIR, 1'b1, 16'h0013, 8'h6E, 3'h0);
    op(OP_BIT, 1'b0, 16'h0013, 8'h00, 3'h0);
    check("bit set", 16'(got.rdata), 16'h0001);
    op(OP_BIT, 1'b0, 16'h0012, 8'h00, 3'h0);
    check("bit clear", 16'(got.rdata), 16'h0000);
    op(OP_DIR, 1'b0, 16'h0013, 8'h00, 3'h0);
    check("byte same addr", 16'(got.rdata), 16'h006E);
    op(OP_DIR, 1'b1, 16'h002F, 8'h00, 3'h0);
    op(OP_BIT, 1'b1, 16'h007F, 8'h01, 3'h0);
    op(OP_DIR, 1'b0, 16'h002F, 8'h00, 3'h0);
    check("top bit", 16'(got.rdata), 16'h0080);
    op(OP_BIT, 1'b1, 16'h0088, 8'h01, 3'h0);
    check("bit sfr", {sfr_req.valid, sfr_req.wr, sfr_req.is_bit},
        16'h0007);
    check("bit sfr addr", 16'(sfr_req.addr), 16'h0088);
    check("bit sfr data", 16'(sfr_req.wdata), 16'h0001);
  endtask

  // Reset in mid-run must bring pointer and stack back
  task automatic t_reset();
    op(OP_DIR, 1'b1, 16'h0081, 8'h5A, 3'h0);
    op(OP_PTR_LD, 1'b1, 16'hBEEF, 8'h00, 3'h0);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    check("sp rerun", 16'(stack_ptr), 16'(SP_RESET));
    check("ptr rerun", data_ptr, 16'h0000);
    op(OP_PUSH, 1'b1, 16'h0000, 8'h3D, 3'h0);
    check("sp rerun push", 16'(stack_ptr), 16'h0008);
    op(OP_DIR, 1'b0, 16'h0008, 8'h00, 3'h0);
    check("rerun push data", 16'(got.rdata), 16'h003D);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    check("ptr reset", data_ptr, 16'h0000);
    t_stack();
    t_code();
    t_xmove();
    t_banks();
    t_upper();
    t_bits();
    t_reset();
    complete_run();
  end
endmodule // testbench
